// ===== mbe_ctrl.sv
// Host controller that reads and page-writes the multiplexed-bus memory.
`timescale 1ns/10ps
`default_nettype none
`include "mbe_defines.svh"
module mbe_ctrl #(
    parameter int          CLK_MHZ  = `MBE_CLK_MHZ,
    parameter int          BLC_US   = `MBE_BLC_SAFE_US,
    parameter int          WC_MS    = `MBE_WC_MAX_MS,
    parameter int          WC_CYC   = WC_MS * 1000 * CLK_MHZ,
    parameter int          PAGE     = `MBE_PAGE_BYTES,
    parameter logic [14:0] UNLK_A0  = `MBE_UNLK_A0,
    parameter logic [7:0]  UNLK_D0  = `MBE_UNLK_D0,
    parameter logic [14:0] UNLK_A1  = `MBE_UNLK_A1,
    parameter logic [7:0]  UNLK_D1  = `MBE_UNLK_D1,
    parameter logic [14:0] UNLK_A2  = `MBE_UNLK_A2,
    parameter logic [7:0]  UNLK_D2  = `MBE_UNLK_D2
) (
    // Clock and reset.
    input  wire logic               sys_clk_i,
    input  wire logic               rst_n_i,
    // User command.
    input  wire logic               req_i,
    input  wire mbe_pkg::mbe_op_t   op_i,
    input  wire mbe_pkg::mbe_addr_t addr_i,
    input  wire logic [7:0]         len_m1_i,
    output logic                    ready_o,
    // Write data stream and read answer.
    input  wire mbe_pkg::mbe_data_t wdata_i,
    output logic                    wdata_take_o,
    output mbe_pkg::mbe_data_t      rdata_o,
    output logic                    rdata_valid_o,
    output logic                    done_o,
    output logic                    timeout_o,
    // Memory pins.
    output logic                    addr_strobe_o,
    output logic                    enable_o,
    output logic                    rd_wr_o,
    output logic                    ce_n_o,
    output logic                    ce_o,
    output logic                    dev_sel_n_o,
    output logic [6:0]              upper_addr_o,
    output mbe_pkg::mbe_data_t      muxed_addr_data_o,
    output logic                    muxed_addr_data_oe_o,
    input  wire mbe_pkg::mbe_data_t muxed_addr_data_i
);
    import mbe_pkg::*;
    localparam int BLC_CYC = BLC_US * CLK_MHZ;
    localparam int BLC_MAX_CYC = `MBE_BLC_MAX_US * CLK_MHZ;
    typedef enum logic [2:0] {C_IDLE, C_UNLK, C_DATA, C_READ, C_WAIT, C_POLL, C_FIN} mbe_st_t;
    mbe_st_t   st_q, st_d;
    logic      go_q, go_d, crd_q, crd_d, rdy_q, rdy_d, take_q, take_d;
    logic      rv_q, rv_d, dn_q, dn_d, to_q, to_d, ce_q, ce_d, sel_q, sel_d;
    logic      pprev_q, pprev_d, phave_q, phave_d;
    mbe_addr_t ca_q, ca_d, base_q, base_d;
    mbe_data_t cd_q, cd_d, rdo_q, rdo_d;
    logic [1:0] ui_q, ui_d;
    logic [7:0] n_q, n_d, left_q, left_d;
    logic [31:0] wc_q, wc_d;
    logic      c_done, c_busy;
    mbe_data_t c_rdata;

    function automatic mbe_addr_t unlk_addr(input logic [1:0] i);
        unlk_addr = (i == 2'h0) ? UNLK_A0 : (i == 2'h1) ? UNLK_A1 : UNLK_A2;
    endfunction : unlk_addr
    function automatic mbe_data_t unlk_data(input logic [1:0] i);
        unlk_data = (i == 2'h0) ? UNLK_D0 : (i == 2'h1) ? UNLK_D1 : UNLK_D2;
    endfunction : unlk_data
    function automatic mbe_addr_t addr_t_add(input mbe_addr_t a, input logic [7:0] n);
        addr_t_add = a + {7'h00, n};
    endfunction : addr_t_add

    mbe_cycle u_cycle (
        .sys_clk_i         (sys_clk_i),
        .rst_n_i           (rst_n_i),
        .go_i              (go_q),
        .rd_i              (crd_q),
        .addr_i            (ca_q),
        .wdata_i           (cd_q),
        .done_o            (c_done),
        .rdata_o           (c_rdata),
        .busy_o            (c_busy),
        .addr_strobe_o     (addr_strobe_o),
        .enable_o          (enable_o),
        .rd_wr_o           (rd_wr_o),
        .ce_n_o            (ce_n_o),
        .mad_o             (muxed_addr_data_o),
        .mad_oe_o          (muxed_addr_data_oe_o),
        .upper_addr_o      (upper_addr_o),
        .muxed_addr_data_i (muxed_addr_data_i)
    );

    always_comb begin
        st_d = st_q; go_d = 1'b0; crd_d = crd_q; rdy_d = 1'b0; take_d = 1'b0;
        rv_d = 1'b0; dn_d = 1'b0; to_d = to_q; ca_d = ca_q; cd_d = cd_q;
        rdo_d = rdo_q; ui_d = ui_q; n_d = n_q; left_d = left_q; base_d = base_q;
        pprev_d = pprev_q; phave_d = phave_q; wc_d = wc_q;
        ce_d = 1'b1;
        sel_d = 1'b0;
        unique case (st_q)
            C_IDLE: begin
                rdy_d = ~req_i;
                if (req_i && rdy_q) begin
                    base_d = addr_i; to_d = 1'b0; ui_d = 2'h0;
                    // Page length clamps to one page.
                    left_d = (len_m1_i > 8'(PAGE - 1)) ? 8'(PAGE - 1) : len_m1_i;
                    n_d = 8'h00;
                    if (op_i == MBE_OP_READ) begin
                        st_d = C_READ; ca_d = addr_i; crd_d = 1'b1; go_d = 1'b1;
                    end else if (op_i == MBE_OP_WRITE_PROT) begin
                        st_d = C_UNLK; crd_d = 1'b0; go_d = 1'b1;
                        ca_d = unlk_addr(2'h0); cd_d = unlk_data(2'h0);
                    end else begin
                        st_d = C_DATA; crd_d = 1'b0; go_d = 1'b1; take_d = 1'b1;
                        ca_d = addr_i; cd_d = wdata_i;
                    end
                end
            end
            C_UNLK: if (c_done) begin
                // Back-to-back loads keep each one well inside the byte-load window.
                go_d = 1'b1;
                if (ui_q == 2'h2) begin
                    st_d = C_DATA; take_d = 1'b1; ca_d = base_q; cd_d = wdata_i;
                end else begin
                    ui_d = ui_q + 2'h1; ca_d = unlk_addr(ui_q + 2'h1); cd_d = unlk_data(ui_q + 2'h1);
                end
            end
            C_DATA: if (c_done) begin
                if (n_q == left_q) begin
                    // Last load; the device starts programming after its timer lapses.
                    st_d = C_WAIT;
                    crd_d = 1'b1;
                    phave_d = 1'b0;
                    wc_d = 32'h0;
                    ca_d = base_q;
                end else begin
                    n_d = n_q + 8'h01; go_d = 1'b1; take_d = 1'b1;
                    // Only the low seven bits advance within the page.
                    ca_d = {base_q[14:7], base_q[6:0] + n_d[6:0]};
                    cd_d = wdata_i;
                end
            end
            C_READ: if (c_done) begin
                rv_d = 1'b1; rdo_d = c_rdata;
                if (n_q == left_q) begin
                    st_d = C_FIN;
                end else begin
                    n_d = n_q + 8'h01; go_d = 1'b1; ca_d = addr_t_add(base_q, n_d);
                end
            end
            C_POLL: begin
                wc_d = wc_q + 32'h1;
                if (c_done) begin
                    phave_d = 1'b1; pprev_d = c_rdata[`MBE_POLL_BIT];
                    if (phave_q && (c_rdata[`MBE_POLL_BIT] == pprev_q)) begin
                        st_d = C_FIN;
                    end else if (wc_q >= 32'(WC_CYC + BLC_CYC)) begin
                        st_d = C_FIN; to_d = 1'b1;
                    end else begin
                        go_d = 1'b1;
                    end
                end
            end
            C_WAIT: begin
                // Polling starts only after the device's byte-load timer has lapsed.
                wc_d = wc_q + 32'h1;
                if (!c_busy && (wc_q == 32'(BLC_MAX_CYC))) begin
                    st_d = C_POLL;
                    go_d = 1'b1;
                    wc_d = 32'h0;
                end
            end
            C_FIN: begin
                dn_d = 1'b1; st_d = C_IDLE;
            end
            default: st_d = C_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_q <= C_IDLE; go_q <= 1'b0; crd_q <= 1'b1; rdy_q <= 1'b0; take_q <= 1'b0;
            rv_q <= 1'b0; dn_q <= 1'b0; to_q <= 1'b0; ce_q <= 1'b1; sel_q <= 1'b0;
            ca_q <= 15'h0000; cd_q <= 8'h00; rdo_q <= 8'h00; ui_q <= 2'h0; n_q <= 8'h00;
            left_q <= 8'h00; base_q <= 15'h0000; pprev_q <= 1'b0; phave_q <= 1'b0; wc_q <= 32'h0;
        end else begin
            st_q <= st_d; go_q <= go_d; crd_q <= crd_d; rdy_q <= rdy_d; take_q <= take_d;
            rv_q <= rv_d; dn_q <= dn_d; to_q <= to_d; ce_q <= ce_d; sel_q <= sel_d;
            ca_q <= ca_d; cd_q <= cd_d; rdo_q <= rdo_d; ui_q <= ui_d; n_q <= n_d;
            left_q <= left_d; base_q <= base_d; pprev_q <= pprev_d; phave_q <= phave_d; wc_q <= wc_d;
        end
    end

    assign ready_o = rdy_q;
    assign wdata_take_o = take_q;
    assign rdata_o = rdo_q;
    assign rdata_valid_o = rv_q;
    assign done_o = dn_q;
    assign timeout_o = to_q;
    assign ce_o = ce_q;
    assign dev_sel_n_o = sel_q;
endmodule : mbe_ctrl
`default_nettype wire

// ===== mbe_defines.svh
// Constants for the multiplexed-bus memory controller.
`ifndef MBE_DEFINES_SVH
`define MBE_DEFINES_SVH
`define MBE_CLK_MHZ        10
`define MBE_BLC_MAX_US     100
`define MBE_BLC_SAFE_US    50
`define MBE_WC_MAX_MS      5
`define MBE_PAGE_BYTES     128
`define MBE_POLL_BIT       6
`define MBE_PHASE_CYCLES   2
`define MBE_UNLK_A0        15'h5555
`define MBE_UNLK_D0        8'hAA
`define MBE_UNLK_A1        15'h2AAA
`define MBE_UNLK_D1        8'h55
`define MBE_UNLK_A2        15'h5555
`define MBE_UNLK_D2        8'hA0
`endif

// ===== mbe_pkg.sv
// Types for the multiplexed-bus memory controller.
package mbe_pkg;
    typedef logic [14:0] mbe_addr_t;
    typedef logic [7:0]  mbe_data_t;
    typedef enum logic [1:0] {
        MBE_OP_READ,
        MBE_OP_WRITE,
        MBE_OP_WRITE_PROT
    } mbe_op_t;
endpackage : mbe_pkg

// ===== mbe_cycle.sv
// One bus cycle on the multiplexed pins: address phase, then data strobe.
`timescale 1ns/10ps
`default_nettype none
`include "mbe_defines.svh"
module mbe_cycle #(
    parameter int PHASE = `MBE_PHASE_CYCLES
) (
    // Clock and reset.
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    // Request.
    input  wire logic             go_i,
    input  wire logic             rd_i,
    input  wire mbe_pkg::mbe_addr_t addr_i,
    input  wire mbe_pkg::mbe_data_t wdata_i,
    output logic                  done_o,
    output mbe_pkg::mbe_data_t    rdata_o,
    output logic                  busy_o,
    // Pins.
    output logic                  addr_strobe_o,
    output logic                  enable_o,
    output logic                  rd_wr_o,
    output logic                  ce_n_o,
    output mbe_pkg::mbe_data_t    mad_o,
    output logic                  mad_oe_o,
    output logic [6:0]            upper_addr_o,
    input  wire mbe_pkg::mbe_data_t muxed_addr_data_i
);
    import mbe_pkg::*;
    typedef enum logic [2:0] {S_IDLE, S_AS, S_HOLD, S_E, S_END} mbe_cst_t;
    mbe_cst_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic as_q, as_d, e_q, e_d, rw_q, rw_d, ce_q, ce_d, oe_q, oe_d, done_q, done_d;
    mbe_data_t mad_q, mad_d, rd_q, rd_d;
    logic [6:0] ua_q, ua_d;
    logic wr_q, wr_d;
    wire logic tick = (cnt_q == 4'(PHASE - 1));
    always_comb begin
        st_d = st_q; cnt_d = tick ? 4'h0 : cnt_q + 4'h1;
        as_d = as_q; e_d = e_q; rw_d = rw_q; ce_d = ce_q; oe_d = oe_q;
        mad_d = mad_q; rd_d = rd_q; ua_d = ua_q; done_d = 1'b0; wr_d = wr_q;
        unique case (st_q)
            S_IDLE: begin
                cnt_d = 4'h0;
                if (go_i) begin
                    // Address flows while strobe is high; low byte on shared pins.
                    st_d = S_AS; as_d = 1'b1; ce_d = 1'b0;
                    mad_d = addr_i[7:0]; oe_d = 1'b1; ua_d = addr_i[14:8];
                    rw_d = rd_i; wr_d = ~rd_i;
                end
            end
            S_AS: if (tick) begin
                st_d = S_HOLD; as_d = 1'b0;
            end
            S_HOLD: if (tick) begin
                // Shared pins turn to data after the address is latched.
                st_d = S_E; e_d = 1'b1;
                oe_d = wr_q; mad_d = wdata_i;
            end
            S_E: if (tick) begin
                // Strobe falls: device captures write data or read data is taken.
                st_d = S_END; e_d = 1'b0;
                if (!wr_q) rd_d = muxed_addr_data_i;
            end
            S_END: if (tick) begin
                st_d = S_IDLE; ce_d = 1'b1; oe_d = 1'b0; rw_d = 1'b1; done_d = 1'b1;
            end
            default: st_d = S_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_q <= S_IDLE; cnt_q <= 4'h0; as_q <= 1'b0; e_q <= 1'b0; rw_q <= 1'b1;
            ce_q <= 1'b1; oe_q <= 1'b0; mad_q <= 8'h00; rd_q <= 8'h00; ua_q <= 7'h00;
            done_q <= 1'b0; wr_q <= 1'b0;
        end else begin
            st_q <= st_d; cnt_q <= cnt_d; as_q <= as_d; e_q <= e_d; rw_q <= rw_d;
            ce_q <= ce_d; oe_q <= oe_d; mad_q <= mad_d; rd_q <= rd_d; ua_q <= ua_d;
            done_q <= done_d; wr_q <= wr_d;
        end
    end
    assign done_o = done_q;
    assign rdata_o = rd_q;
    assign busy_o = (st_q != S_IDLE);
    assign addr_strobe_o = as_q;
    assign enable_o = e_q;
    assign rd_wr_o = rw_q;
    assign ce_n_o = ce_q;
    assign mad_o = mad_q;
    assign mad_oe_o = oe_q;
    assign upper_addr_o = ua_q;
endmodule : mbe_cycle
`default_nettype wire

// ===== mbe_ctrl_monitor.sv
// Pin-level assertions for the multiplexed-bus memory controller.
`timescale 1ns/10ps
`default_nettype none
module mbe_ctrl_monitor (
    // Clock and reset.
    input wire logic               sys_clk_i,
    input wire logic               rst_n_i,
    // Memory pins.
    input wire logic               addr_strobe_o,
    input wire logic               enable_o,
    input wire logic               rd_wr_o,
    input wire logic               ce_n_o,
    input wire logic               ce_o,
    input wire logic               dev_sel_n_o,
    input wire logic [6:0]         upper_addr_o,
    input wire mbe_pkg::mbe_data_t muxed_addr_data_o,
    input wire logic               muxed_addr_data_oe_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    ce_high_a: assert property (ce_o) else $error("ce low");
    sel_ground_a: assert property (!dev_sel_n_o) else $error("sel high");
    strobe_select_a: assert property (enable_o |-> !ce_n_o) else $error("strobe unselected");
    addr_drive_a: assert property (addr_strobe_o |-> muxed_addr_data_oe_o && !ce_n_o) else $error("addr");
    idle_release_a: assert property (ce_n_o |-> !muxed_addr_data_oe_o && !enable_o) else $error("idle");
    upper_hold_a: assert property ($fell(addr_strobe_o) |-> $stable(upper_addr_o) [*4]) else $error("upper");
    phase_order_a: assert property ($rose(addr_strobe_o) |-> ##2 !addr_strobe_o ##2 enable_o) else $error("ord");
    rw_steady_a: assert property (enable_o |-> $stable(rd_wr_o)) else $error("rw moved");
    wr_hold_a: assert property ($fell(enable_o) && !rd_wr_o |-> muxed_addr_data_oe_o
        && $stable(muxed_addr_data_o)) else $error("wr hold");
    rd_release_a: assert property (enable_o && rd_wr_o |-> !muxed_addr_data_oe_o) else $error("rd drive");
endmodule : mbe_ctrl_monitor
bind mbe_ctrl mbe_ctrl_monitor u_mon (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_strobe_o(addr_strobe_o),
    .enable_o(enable_o), .rd_wr_o(rd_wr_o), .ce_n_o(ce_n_o), .ce_o(ce_o), .dev_sel_n_o(dev_sel_n_o),
    .upper_addr_o(upper_addr_o), .muxed_addr_data_o(muxed_addr_data_o),
    .muxed_addr_data_oe_o(muxed_addr_data_oe_o));
`default_nettype wire

// ===== mbe_mem_model.sv
// Behavioural model of the multiplexed-bus memory device.
`timescale 1ns/10ps
`default_nettype none
`include "mbe_defines.svh"
module mbe_mem_model #(
    parameter int BLC_CYC  = 1000,
    parameter int PROG_CYC = 600
) (
    // Clock for the load timer and test control.
    input  wire logic               sys_clk_i,
    input  wire logic               stuck_i,
    // Device pins.
    input  wire logic               stb_i,
    input  wire logic               en_i,
    input  wire logic               rw_i,
    input  wire logic               ce_n_i,
    input  wire logic               ce_i,
    input  wire logic               sel_n_i,
    input  wire logic [6:0]         up_i,
    input  wire mbe_pkg::mbe_data_t bus_i,
    output mbe_pkg::mbe_data_t      dout_o
);
    logic [7:0]  mem [0:32767];
    logic [14:0] lat_a;
    logic [7:0]  last_d = 8'h00;
    logic        tog = 1'b0;
    logic        busy = 1'b0;
    logic        viol = 1'b0;
    int          unlk = 0;
    int          tmr = -1;
    int          prog = 0;
    int          n_poll = 0;
    logic [14:0] pa [$];
    logic [7:0]  pd [$];
    wire         sel = !ce_n_i && ce_i && !sel_n_i;
    wire         rd_act = sel && en_i && rw_i;
    initial begin
        for (int i = 0; i < 32768; i++) mem[i] = 8'h5A ^ i[7:0];
    end
    always @(negedge stb_i) if (sel) lat_a = {up_i, bus_i};
    assign dout_o = rd_act ? (busy ? {mem[lat_a][7], tog, mem[lat_a][5:0]} : mem[lat_a]) : ~last_d;
    always @(posedge sys_clk_i) if (rd_act) last_d <= dout_o;
    always @(posedge en_i) begin
        if (sel && rw_i && busy) begin
            tog = ~tog;
            n_poll++;
        end
        if (sel && !rw_i) tmr = BLC_CYC;
    end
    always @(negedge en_i) begin
        if (sel && !rw_i && !busy) begin
            if (unlk < 3) begin
                unlk = ({lat_a, bus_i} == (unlk == 0 ? {`MBE_UNLK_A0, `MBE_UNLK_D0} : unlk == 1 ?
                    {`MBE_UNLK_A1, `MBE_UNLK_D1} : {`MBE_UNLK_A2, `MBE_UNLK_D2})) ? unlk + 1 : 0;
            end else begin
                if (pa.size() > 0 && pa[0][14:7] != lat_a[14:7]) viol = 1'b1;
                if (pa.size() >= 128) viol = 1'b1;
                pa.push_back(lat_a);
                pd.push_back(bus_i);
            end
        end
    end
    always @(posedge sys_clk_i) begin
        if (tmr > 0) tmr = tmr - 1;
        else if (tmr == 0) begin
            tmr = -1;
            if (unlk == 3) begin
                foreach (pa[i]) mem[pa[i]] = pd[i];
                busy = 1'b1;
                prog = PROG_CYC;
            end
            unlk = 0;
            pa.delete();
            pd.delete();
        end else if (busy && !stuck_i) begin
            prog--;
            if (prog == 0) busy = 1'b0;
        end
    end
endmodule : mbe_mem_model
`default_nettype wire

// ===== mbe_tb.sv
// Self-checking testbench for the multiplexed-bus memory controller.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import mbe_pkg::*;
    logic       sys_clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       req_i = 1'b0;
    mbe_op_t    op_i = MBE_OP_READ;
    mbe_addr_t  addr_i = 15'h0000;
    logic [7:0] len_m1_i = 8'h00;
    mbe_data_t  wdata_i = 8'h00;
    logic       stuck = 1'b0;
    logic       ready_o, wdata_take_o, rdata_valid_o, done_o, timeout_o, oe, dn_to;
    logic       addr_strobe_o, enable_o, rd_wr_o, ce_n_o, ce_o, dev_sel_n_o;
    logic [6:0] upper_addr_o;
    mbe_data_t  rdata_o, dout, mdl_out;
    wire  [7:0] bus = oe ? dout : mdl_out;
    int         n_mismatch = 0;
    int         samples_checked = 0;
    int         takes;
    mbe_data_t  rdq [$];
    mbe_ctrl #(.WC_CYC(2000)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .op_i(op_i),
        .addr_i(addr_i), .len_m1_i(len_m1_i), .ready_o(ready_o), .wdata_i(wdata_i), .wdata_take_o(wdata_take_o),
        .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .done_o(done_o), .timeout_o(timeout_o),
        .addr_strobe_o(addr_strobe_o), .enable_o(enable_o), .rd_wr_o(rd_wr_o), .ce_n_o(ce_n_o), .ce_o(ce_o),
        .dev_sel_n_o(dev_sel_n_o), .upper_addr_o(upper_addr_o), .muxed_addr_data_o(dout),
        .muxed_addr_data_oe_o(oe), .muxed_addr_data_i(bus));
    mbe_mem_model #(.BLC_CYC(1000), .PROG_CYC(600)) mdl (.sys_clk_i(sys_clk_i), .stuck_i(stuck),
        .stb_i(addr_strobe_o), .en_i(enable_o), .rw_i(rd_wr_o), .ce_n_i(ce_n_o), .ce_i(ce_o),
        .sel_n_i(dev_sel_n_o), .up_i(upper_addr_o), .bus_i(bus), .dout_o(mdl_out));
    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    function automatic mbe_data_t blank_byte(input mbe_addr_t a);
        return 8'h5A ^ a[7:0];
    endfunction : blank_byte
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic do_cmd(input mbe_op_t op, input mbe_addr_t a, input logic [7:0] lm1, input mbe_data_t base);
        int   n;
        logic drop;
        n = 0;
        takes = 0;
        dn_to = 1'b0;
        rdq.delete();
        @(negedge sys_clk_i);
        req_i = 1'b1;
        op_i = op;
        addr_i = a;
        len_m1_i = lm1;
        wdata_i = base;
        drop = ready_o;
        while (n < 80000) begin
            @(negedge sys_clk_i);
            n++;
            if (drop) req_i = 1'b0;
            drop = req_i && ready_o;
            if (wdata_take_o) begin
                takes++;
                wdata_i = base + takes[7:0];
            end
            if (rdata_valid_o) rdq.push_back(rdata_o);
            if (done_o) begin
                dn_to = timeout_o;
                break;
            end
        end
        chk("done", 1, n < 80000);
    endtask : do_cmd
    task automatic rd_cmp(input mbe_addr_t a, input mbe_data_t e0, input mbe_data_t e1);
        do_cmd(MBE_OP_READ, a, 8'h01, 8'h00);
        chk("nread", 2, rdq.size());
        chk("rdata0", e0, rdq[0]);
        chk("rdata1", e1, rdq[1]);
    endtask : rd_cmp
    task automatic t_idle();
        chk("ce_n", 1, ce_n_o);
        chk("oe", 0, oe);
        chk("ce", 1, ce_o);
        chk("sel_n", 0, dev_sel_n_o);
        $display("test idle done");
    endtask : t_idle
    task automatic t_page_wrap();
        do_cmd(MBE_OP_WRITE_PROT, 15'h12FE, 8'h03, 8'hC0);
        chk("takes", 4, takes);
        chk("busy", 0, mdl.busy);
        chk("polled", 1, mdl.n_poll > 0);
        chk("viol", 0, mdl.viol);
        chk("timeout", 0, dn_to);
        rd_cmp(15'h12FE, 8'hC0, 8'hC1);
        rd_cmp(15'h127F, blank_byte(15'h127F), 8'hC2);
        rd_cmp(15'h1281, 8'hC3, blank_byte(15'h1282));
        $display("test page wrap done");
    endtask : t_page_wrap
    task automatic t_no_unlock();
        do_cmd(MBE_OP_WRITE, 15'h0300, 8'h01, 8'h11);
        rd_cmp(15'h0300, blank_byte(15'h0300), blank_byte(15'h0301));
        $display("test no unlock done");
    endtask : t_no_unlock
    task automatic t_full_page();
        do_cmd(MBE_OP_WRITE_PROT, 15'h4000, 8'hC8, 8'h00);
        chk("takes", 128, takes);
        chk("viol", 0, mdl.viol);
        rd_cmp(15'h407F, 8'h7F, blank_byte(15'h4080));
        $display("test full page done");
    endtask : t_full_page
    task automatic t_stuck();
        stuck = 1'b1;
        do_cmd(MBE_OP_WRITE_PROT, 15'h0010, 8'h00, 8'h77);
        chk("timeout", 1, dn_to);
        stuck = 1'b0;
        $display("test stuck done");
    endtask : t_stuck
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #5_000_000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        t_idle();
        t_page_wrap();
        t_no_unlock();
        t_full_page();
        t_stuck();
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
